// ==== hw/hsc_top.sv ====
// What this block does
// - hardware compare acts on the counting edge
// - scan compares sampled once per scan tick
// - compare hit drives output, skipping scan refresh
// - at most six hardware comparators active
// - single counters take up to 60/10 kHz
// - free budget: 200 kHz minus 40 each
// - compare budget: 60 minus 5, 20 each
// - budget applies for multi-counter or extra functions
// - single counter direction from software bit
// - dual/quadrature expose actual direction flag
// - global contact enables input function switching
// - switch a remaps dual and quadrature variant
// - counters are 32-bit signed ring counters
// - quadrature decodes phase relation for direction
// - variants lose reset; one moves to pins 6/7
`timescale 1ns/1ps
module hsc_top
  import hsc_pkg::*;
#(
  parameter int WIN_CYCLES  = WIN_CYC,
  parameter int SCAN_CYCLES = SCAN_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // counter input points and output points
  input  wire logic [7:0]  x_in,
  output logic [7:0]       y_out,
  output logic             overload
);
  import hsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [2:0]    ctrl_reg;
  logic [NC-1:0] en_reg;
  logic [NC-1:0] dirsel_reg;
  logic [NC-1:0] dirmon_reg;
  logic [4:0]    csel_reg;
  logic [2:0]    axes_reg;
  logic [2:0]    pw_reg;
  logic [7:0]    oimg_reg;
  logic [4:0]    ssel_reg;
  logic [31:0]   slo_reg;
  logic [31:0]   shi_reg;
  logic [5:0]    sres_reg;
  logic [7:0]    x_prev_reg;
  logic [15:0]   scan_cnt_reg;
  logic          scan_tick_reg;
  logic [15:0]   win_cnt_reg;
  logic [20:0]   ev_cnt_reg;
  logic [20:0]   rate_reg;
  logic [9:0]    budget_reg;
  logic [31:0]   cnt_reg    [NC];
  logic [31:0]   cnt_nx     [NC];
  logic [14:0]   cmp_cfg_reg[NCMP];
  logic [31:0]   cmp_lo_reg [NCMP];
  logic [31:0]   cmp_hi_reg [NCMP];
  logic [7:0]    cset       [NCMP];
  logic [7:0]    cclr       [NCMP];
  logic [NC-1:0] inc_w;
  logic [NC-1:0] dec_w;
  logic [NC-1:0] rz_w;
  logic [NC-1:0] chg;

  ////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state so read data leaves a flop
  wire logic        acc     = psel & penable;
  wire logic        done    = acc & pready;
  wire logic        wr      = done & pwrite;
  wire logic [3:0]  cslot   = paddr[7:4] - CMP_FIRST;
  wire logic [1:0]  cword   = paddr[3:2];
  wire logic        cmp_hit = paddr[7:4] >= CMP_FIRST && paddr[7:4] <= CMP_LAST
                              && cword != 2'h3;
  wire logic        rd_hit  = paddr[1:0] == 2'h0 && (cmp_hit || paddr <= OFF_SRES);
  wire logic [NC-1:0] clr_w = (wr && paddr == OFF_CLR) ? pwdata[NC-1:0] : '0;
  wire logic [31:0] cval    = (csel_reg < 5'(NC)) ? cnt_reg[csel_reg] : 32'h0;
  wire logic [2:0]  ncmp_act;
  wire logic        cmp_any = ncmp_act != 3'h0;
  wire logic        applies;
  wire logic [31:0] cmp_rd  = cword == 2'h0 ? {17'h0, cmp_cfg_reg[cslot[2:0]]} :
                              cword == 2'h1 ? cmp_lo_reg[cslot[2:0]] :
                                              cmp_hi_reg[cslot[2:0]];
  wire logic [31:0] rdata   =
    !rd_hit            ? 32'h0 :
    cmp_hit            ? cmp_rd :
    paddr == OFF_CTRL  ? {29'h0, ctrl_reg} :
    paddr == OFF_EN    ? {11'h0, en_reg} :
    paddr == OFF_DSEL  ? {21'h0, dirsel_reg[NS-1:0]} :
    paddr == OFF_DMON  ? {11'h0, dirmon_reg} :
    paddr == OFF_CSEL  ? {27'h0, csel_reg} :
    paddr == OFF_CVAL  ? cval :
    paddr == OFF_LOAD  ? {25'h0, pw_reg, 1'b0, axes_reg} :
    paddr == OFF_STAT  ? {6'h0, budget_reg, 11'h0, ncmp_act, applies, overload} :
    paddr == OFF_RATE  ? {11'h0, rate_reg} :
    paddr == OFF_OUT   ? {24'h0, y_out} :
    paddr == OFF_SSEL  ? {27'h0, ssel_reg} :
    paddr == OFF_SLO   ? slo_reg :
    paddr == OFF_SHI   ? shi_reg :
    paddr == OFF_SRES  ? {26'h0, sres_reg} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      prdata  <= rdata;
      pslverr <= acc & ~pready & ~rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= 3'h0;
      en_reg     <= '0;
      dirsel_reg <= '0;
      csel_reg   <= 5'h0;
      axes_reg   <= 3'h0;
      pw_reg     <= 3'h0;
      oimg_reg   <= 8'h0;
      ssel_reg   <= 5'h0;
      slo_reg    <= 32'h0;
      shi_reg    <= 32'h0;
    end else if (wr && rd_hit) begin
      case (paddr)
        OFF_CTRL: ctrl_reg <= pwdata[2:0];
        OFF_EN:   en_reg <= pwdata[NC-1:0];
        OFF_DSEL: dirsel_reg <= {10'h0, pwdata[NS-1:0]};
        OFF_CSEL: csel_reg <= pwdata[4:0];
        OFF_LOAD: begin
          axes_reg <= pwdata[2:0];
          pw_reg   <= pwdata[6:4];
        end
        OFF_OUT:  oimg_reg <= pwdata[7:0];
        OFF_SSEL: ssel_reg <= pwdata[4:0];
        OFF_SLO:  slo_reg <= pwdata;
        OFF_SHI:  shi_reg <= pwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counters; inputs are sampled at pclk, far above any counting rate
  wire logic [7:0] rise = x_in & ~x_prev_reg;
  wire logic [7:0] fall = ~x_in & x_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) x_prev_reg <= 8'h0;
    else          x_prev_reg <= x_in;
  end

  for (genvar i = 0; i < NC; i++) begin : g_cnt
    wire logic sw_a = ctrl_reg[0] & ctrl_reg[1];
    wire logic sw_b = ctrl_reg[0] & ctrl_reg[2];
    wire logic [11:0] map =
      (i == IDX_DUAL_ALT && sw_a) ? MAP_DUAL_ALT :
      (i == IDX_QUAD_A   && sw_a) ? MAP_QUAD_A :
      (i == IDX_QUAD_B   && sw_b) ? MAP_QUAD_B : HSC_MAP[i];
    wire logic [2:0] pa = map[9:7];
    wire logic [2:0] pb = map[6:4];
    wire logic [1:0] md = map[11:10];
    wire logic up =
      md == HSC_M_SINGLE ? rise[pa] & ~dirsel_reg[i] :
      md == HSC_M_DUAL   ? rise[pa] & ~rise[pb] :
                           (rise[pa] & ~x_in[pb]) | (fall[pa] & x_in[pb]);
    wire logic dn =
      md == HSC_M_SINGLE ? rise[pa] & dirsel_reg[i] :
      md == HSC_M_DUAL   ? rise[pb] & ~rise[pa] :
                           (rise[pa] & x_in[pb]) | (fall[pa] & ~x_in[pb]);
    assign rz_w[i]  = clr_w[i] | (map[3] & x_in[map[2:0]]);
    assign inc_w[i] = en_reg[i] & up;
    assign dec_w[i] = en_reg[i] & dn;
    assign chg[i]   = ~rz_w[i] & (inc_w[i] | dec_w[i]);
    // plain 32-bit add and subtract give the signed ring wrap
    assign cnt_nx[i] = rz_w[i] ? CNT_RST :
                       inc_w[i] ? cnt_reg[i] + 32'h1 :
                       dec_w[i] ? cnt_reg[i] - 32'h1 : cnt_reg[i];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg[i]    <= CNT_RST;
        dirmon_reg[i] <= 1'b0;
      end else begin
        cnt_reg[i] <= cnt_nx[i];
        if (md != HSC_M_SINGLE && chg[i]) dirmon_reg[i] <= dec_w[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hardware comparators, evaluated on the count's next value
  function automatic logic [7:0] rotl8(input logic [7:0] v, input logic [2:0] s);
    logic [15:0] w;
    w = {v, v} << s;
    return w[15:8];
  endfunction : rotl8

  for (genvar j = 0; j < NCMP; j++) begin : g_cmp
    wire logic [14:0] cfg  = cmp_cfg_reg[j];
    wire logic [4:0]  sel  = (cfg[8:4] < 5'(NC)) ? cfg[8:4] : 5'h0;
    wire logic        hit  = cfg[0] && chg[sel];
    wire logic signed [31:0] v  = cnt_nx[sel];
    wire logic signed [31:0] lo = cmp_lo_reg[j];
    wire logic signed [31:0] hi = cmp_hi_reg[j];
    wire logic [2:0]  zone = v < lo ? 3'h1 : v > hi ? 3'h4 : 3'h2;
    assign cset[j] = !hit ? 8'h0 :
      cfg[2:1] == HSC_K_SET  ? (v == lo ? rotl8(8'h01, cfg[14:12]) : 8'h0) :
      cfg[2:1] == HSC_K_ZONE ? rotl8({5'h0, zone}, cfg[14:12]) : 8'h0;
    assign cclr[j] = !hit ? 8'h0 :
      cfg[2:1] == HSC_K_RST  ? (v == lo ? rotl8(8'h01, cfg[14:12]) : 8'h0) :
      cfg[2:1] == HSC_K_ZONE ? rotl8({5'h0, ~zone}, cfg[14:12]) : 8'h0;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cmp_cfg_reg[j] <= 15'h0;
        cmp_lo_reg[j]  <= 32'h0;
        cmp_hi_reg[j]  <= 32'h0;
      end else if (wr && cmp_hit && cslot == 4'(j)) begin
        if (cword == 2'h0) cmp_cfg_reg[j] <= pwdata[14:0];
        if (cword == 2'h1) cmp_lo_reg[j]  <= pwdata;
        if (cword == 2'h2) cmp_hi_reg[j]  <= pwdata;
      end
    end
  end

  logic [7:0] set_all;
  logic [7:0] clr_all;
  logic [2:0] nact;
  logic [4:0] nen;
  logic [4:0] nstep;
  always_comb begin
    set_all = 8'h0;
    clr_all = 8'h0;
    nact    = 3'h0;
    for (int j = 0; j < NCMP; j++) begin
      set_all = set_all | cset[j];
      clr_all = clr_all | cclr[j];
      nact    = nact + {2'h0, cmp_cfg_reg[j][0]};
    end
    nen   = 5'h0;
    nstep = 5'h0;
    for (int i = 0; i < NC; i++) begin
      nen   = nen + {4'h0, en_reg[i]};
      nstep = nstep + {4'h0, chg[i]};
    end
  end
  assign ncmp_act = nact;

  // the scan refresh only rewrites outputs once per scan; a compare hit in
  // that same cycle still wins, so a fast match stands until the next scan refresh
  wire logic [7:0] y_base = scan_tick_reg ? oimg_reg : y_out;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) y_out <= 8'h0;
    else          y_out <= (y_base & ~clr_all) | set_all;
  end

  ////////////////////////////////////////////////////////////////////////
  // scan-rate compare: result lags the count by up to one scan
  wire logic scan_end = scan_cnt_reg == 16'(SCAN_CYCLES - 1);
  wire logic signed [31:0] sv  = (ssel_reg < 5'(NC)) ? cnt_reg[ssel_reg] : 32'h0;
  wire logic signed [31:0] slo = slo_reg;
  wire logic signed [31:0] shi = shi_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt_reg  <= 16'h0;
      scan_tick_reg <= 1'b0;
      sres_reg      <= 6'h0;
    end else begin
      scan_cnt_reg  <= scan_end ? 16'h0 : scan_cnt_reg + 16'h1;
      scan_tick_reg <= scan_end;
      if (scan_tick_reg)
        sres_reg <= {sv > shi, sv >= slo && sv <= shi, sv < slo,
                     sv > slo, sv == slo, sv < slo};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overall rate budget
  wire logic [9:0] bud_base = cmp_any ? BUD_CMP_KHZ : BUD_FREE_KHZ;
  wire logic [9:0] bud_cut  = cmp_any ?
    BUD_CMP_AX * {7'h0, axes_reg} + BUD_CMP_PW * {7'h0, pw_reg} :
    BUD_FREE_STEP * ({7'h0, axes_reg} + {7'h0, pw_reg});
  wire logic [9:0] bud_now  = bud_cut >= bud_base ? 10'h0 : bud_base - bud_cut;
  assign applies = nen >= 5'h2 || cmp_any || axes_reg != 3'h0 || pw_reg != 3'h0;
  wire logic win_end = win_cnt_reg == 16'(WIN_CYCLES - 1);
  wire logic [20:0] ev_tot = ev_cnt_reg + {16'h0, nstep};
  wire logic over = win_end && applies && ev_tot > {11'h0, budget_reg};
  wire logic ovl_clr = wr && paddr == OFF_STAT && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_reg <= 16'h0;
      ev_cnt_reg  <= 21'h0;
      rate_reg    <= 21'h0;
      budget_reg  <= 10'h0;
      overload    <= 1'b0;
    end else begin
      win_cnt_reg <= win_end ? 16'h0 : win_cnt_reg + 16'h1;
      ev_cnt_reg  <= win_end ? 21'h0 : ev_tot;
      if (win_end) rate_reg <= ev_tot;
      budget_reg  <= bud_now;
      overload    <= over | (overload & ~ovl_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire logic [4:0] c0_sel = cmp_cfg_reg[0][8:4];
  wire logic [2:0] c0_tgt = cmp_cfg_reg[0][14:12];
  sequence s_set_hit;
    cmp_cfg_reg[0][0] && cmp_cfg_reg[0][2:1] == HSC_K_SET && c0_sel < 5'h15
      && chg[c0_sel] && cnt_nx[c0_sel] == cmp_lo_reg[0] && !wr;
  endsequence
  property p_cmp_set;
    s_set_hit |=> y_out[$past(c0_tgt)];
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare set missed");

  property p_scan;
    !scan_tick_reg |=> $stable(sres_reg);
  endproperty
  a_scan: assert property (p_scan) else $error("scan result moved off tick");

  property p_dir_sel;
    en_reg[3] && rise[3] && !clr_w[3] |=>
      cnt_reg[3] == ($past(dirsel_reg[3]) ? $past(cnt_reg[3]) - 32'h1
                                          : $past(cnt_reg[3]) + 32'h1);
  endproperty
  a_dir_sel: assert property (p_dir_sel) else $error("direction select wrong");

  property p_wrap;
    cnt_reg[0] == CNT_MAX && inc_w[0] && !rz_w[0] |=> cnt_reg[0] == CNT_MIN;
  endproperty
  a_wrap: assert property (p_wrap) else $error("ring wrap wrong");

  sequence s_dual_down;
    dec_w[16] && !rz_w[16];
  endsequence
  property p_dir_mon;
    s_dual_down |=> dirmon_reg[16] && cnt_reg[16] == $past(cnt_reg[16]) - 32'h1;
  endproperty
  a_dir_mon: assert property (p_dir_mon) else $error("direction flag wrong");

  property p_bud_free;
    !cmp_any && axes_reg == 3'h2 && pw_reg == 3'h1 |=> budget_reg == 10'h050;
  endproperty
  a_bud_free: assert property (p_bud_free) else $error("free budget wrong");

  property p_bud_cmp;
    cmp_any && axes_reg == 3'h2 && pw_reg == 3'h1 |=> budget_reg == 10'h01E;
  endproperty
  a_bud_cmp: assert property (p_bud_cmp) else $error("compare budget wrong");

  property p_ovl;
    over |=> overload ##1 (overload || $past(ovl_clr));
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload not held");

  property p_remap_b;
    ctrl_reg == 3'h5 && en_reg[19] && rise[6] && !x_in[7] && !clr_w[19]
      |=> cnt_reg[19] == $past(cnt_reg[19]) + 32'h1;
  endproperty
  a_remap_b: assert property (p_remap_b) else $error("variant remap wrong");
endmodule : hsc_top

// ==== hw/hsc_pkg.sv ====
package hsc_pkg;
  localparam int NC       = 21;
  localparam int NS       = 11;
  localparam int NCMP     = 6;
  localparam int CLK_HZ   = 50_000_000;
  // 1 ms window, so events counted per window read directly as kHz
  localparam int WIN_US   = 1000;
  localparam int WIN_CYC  = CLK_HZ / 1_000_000 * WIN_US;
  localparam int SCAN_US  = 1000;
  localparam int SCAN_CYC = CLK_HZ / 1_000_000 * SCAN_US;

  localparam logic [9:0] BUD_FREE_KHZ  = 10'h0C8;
  localparam logic [9:0] BUD_FREE_STEP = 10'h028;
  localparam logic [9:0] BUD_CMP_KHZ   = 10'h03C;
  localparam logic [9:0] BUD_CMP_AX    = 10'h005;
  localparam logic [9:0] BUD_CMP_PW    = 10'h014;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EN   = 8'h04;
  localparam logic [7:0] OFF_DSEL = 8'h08;
  localparam logic [7:0] OFF_CLR  = 8'h0C;
  localparam logic [7:0] OFF_DMON = 8'h10;
  localparam logic [7:0] OFF_CSEL = 8'h14;
  localparam logic [7:0] OFF_CVAL = 8'h18;
  localparam logic [7:0] OFF_LOAD = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_RATE = 8'h24;
  localparam logic [7:0] OFF_OUT  = 8'h28;
  localparam logic [7:0] OFF_SSEL = 8'h2C;
  localparam logic [7:0] OFF_SLO  = 8'h30;
  localparam logic [7:0] OFF_SHI  = 8'h34;
  localparam logic [7:0] OFF_SRES = 8'h38;
  localparam logic [3:0] CMP_FIRST = 4'h4;
  localparam logic [3:0] CMP_LAST  = 4'h9;

  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] CNT_MIN = 32'h8000_0000;

  typedef enum logic [1:0] {
    HSC_K_SET  = 2'h0,
    HSC_K_RST  = 2'h1,
    HSC_K_ZONE = 2'h2
  } hsc_kind_t;

  typedef enum logic [1:0] {
    HSC_M_SINGLE = 2'h0,
    HSC_M_DUAL   = 2'h1,
    HSC_M_QUAD   = 2'h2
  } hsc_mode_t;

  // map word: [11:10] mode, [9:7] pin a, [6:4] pin b, [3] has reset, [2:0] reset pin
  localparam logic [11:0] HSC_MAP [NC] = '{
    12'h000, 12'h080, 12'h100, 12'h180, 12'h200, 12'h280,
    12'h009, 12'h10B, 12'h18C, 12'h009, 12'h10B,
    12'h410, 12'h41A, 12'h5CD, 12'h41A, 12'h5CD,
    12'h810, 12'h81A, 12'h9CD, 12'h81A, 12'h9CD};
  localparam int IDX_DUAL_ALT = 13;
  localparam int IDX_QUAD_A   = 18;
  localparam int IDX_QUAD_B   = 19;
  localparam logic [11:0] MAP_DUAL_ALT = 12'h5C0;
  localparam logic [11:0] MAP_QUAD_A   = 12'h9C0;
  localparam logic [11:0] MAP_QUAD_B   = 12'hB70;
endpackage : hsc_pkg

// ==== tb/hsc_enc_model.sv ====
`timescale 1ns/1ps
module hsc_enc_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // step request
  input  wire logic step,
  input  wire logic dir,
  // phase outputs
  output logic      pha,
  output logic      phb
);
  logic [1:0] ph_reg;
  logic [1:0] ph_next;

  // gray walk keeps the two phases a quarter cycle apart; dir 1 walks back
  assign ph_next = dir ? ph_reg - 2'h1 : ph_reg + 2'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg <= 2'h0;
    end else if (step) begin
      ph_reg <= ph_next;
    end
  end
  assign pha = ph_reg[0] ^ ph_reg[1];
  assign phb = ph_reg[1];
endmodule : hsc_enc_model

// ==== tb/tb_high_speed_counter_compare_budget.sv ====
`timescale 1ns/1ps
module tb_high_speed_counter_compare_budget;
  import hsc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, stp, dr;
  logic [7:0]  paddr, xb, y_out;
  logic [31:0] pwdata, prdata, v;
  logic        pready, pslverr, overload, ea, eb, er;
  wire logic [7:0] x_in = {xb[7:2], eb, ea};
  int          miscompares, checks, e3, e16, qph, n;
  int          ten[5] = '{32'h8, 32'h18, 32'h8, 32'h8, 32'h8};
  int          tax[5] = '{0, 2, 2, 2, 3};
  int          tpw[5] = '{0, 0, 1, 1, 3};
  int          tnc[5] = '{0, 0, 0, 6, 0};

  hsc_top #(.WIN_CYCLES(100), .SCAN_CYCLES(64)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .x_in(x_in), .y_out(y_out),
    .overload(overload));
  hsc_enc_model enc_u (.pclk(pclk), .presetn(presetn), .step(stp), .dir(dr),
    .pha(ea), .phb(eb));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, prdata and pslverr are read as they stood at this rising edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (pready !== 1'b1) chk(1'b0, 1'b1, "no pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, er);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, v, er);
  endtask : rd
  task automatic rdcnt(input logic [31:0] i);
    wr(OFF_CSEL, i);
    rd(OFF_CVAL);
  endtask : rdcnt
  // held two edges so the edge detector sees one clean rise per pulse
  task automatic pulse(input int p);
    @(posedge pclk);
    xb[p] <= 1'b1;
    repeat (2) @(posedge pclk);
    xb[p] <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse
  task automatic qstep(input logic d);
    @(posedge pclk);
    stp <= 1'b1; dr <= d;
    @(posedge pclk);
    stp <= 1'b0;
    repeat ($urandom_range(3, 1)) @(posedge pclk);
    if (!d && qph % 2 == 0) e16++;
    if (d && qph % 2 == 1) e16--;
    qph = d ? (qph + 3) % 4 : (qph + 1) % 4;
  endtask : qstep
  function automatic int bud(input int a, input int p, input int c);
    int r;
    r = (c > 0) ? 60 - 5 * a - 20 * p : 200 - 40 * (a + p);
    return (r < 0) ? 0 : r;
  endfunction : bud
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    end_of_test;
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; xb = 8'h00; stp = 1'b0; dr = 1'b0;
    miscompares = 0; checks = 0; e3 = 0; e16 = 0; qph = 0;
    void'($urandom(86));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(y_out, 8'h00, "y_out at reset");
    rdcnt(32'h3);
    chk(v, CNT_RST, "counter at reset");
    rd(8'h3C);
    chk(v, 32'h0, "unmapped read data");
    chk({31'h0, er}, 32'h1, "unmapped read error");
    $display("test reset done");
    // single counter: up then further down, crossing zero
    wr(OFF_EN, 32'h0001_0008);
    for (int d = 0; d < 2; d++) begin
      wr(OFF_DSEL, d ? 32'h8 : 32'h0);
      n = d ? $urandom_range(6, 4) : $urandom_range(3, 1);
      repeat (n) pulse(3);
      e3 += d ? -n : n;
      rdcnt(32'h3);
      chk(v, 32'(e3), "single count");
    end
    $display("test single done");
    // hardware compare hits in the counting edge itself
    wr(OFF_CLR, 32'h8);
    wr(OFF_DSEL, 32'h0);
    wr(8'h44, 32'h2);
    wr(8'h40, 32'h5031);
    pulse(3);
    @(posedge pclk);
    xb[3] <= 1'b1;
    @(negedge pclk);
    chk(y_out[5], 1'b0, "hit too early");
    @(negedge pclk);
    chk(y_out[5], 1'b1, "hit not on count edge");
    @(posedge pclk);
    xb[3] <= 1'b0;
    wr(OFF_SSEL, 32'h3);
    wr(OFF_SLO, 32'h1);
    wr(OFF_SHI, 32'h5);
    repeat (140) @(posedge pclk);
    rd(OFF_SRES);
    chk(v, 32'h14, "scan compare");
    $display("test compare done");
    // quadrature from the encoder, forward then backward steps
    wr(OFF_CLR, 32'h0001_0000);
    repeat ($urandom_range(8, 3)) qstep(1'b0);
    rdcnt(32'd16);
    chk(v, 32'(e16), "quad up");
    rd(OFF_DMON);
    chk(v[16], 1'b0, "dir flag up");
    repeat ($urandom_range(9, 4)) qstep(1'b1);
    rdcnt(32'd16);
    chk(v, 32'(e16), "quad down");
    rd(OFF_DMON);
    chk(v[16], 1'b1, "dir flag down");
    $display("test quadrature done");
    // variant without reset only when the contact is on too
    wr(OFF_EN, 32'h2008);
    wr(OFF_CTRL, 32'h2);
    xb[5] <= 1'b1;
    wr(OFF_CLR, 32'h2000);
    pulse(3);
    rdcnt(32'd13);
    chk(v, 32'h0, "reset pin ignored");
    wr(OFF_CTRL, 32'h3);
    pulse(3);
    rdcnt(32'd13);
    chk(v, 32'h1, "variant still reset");
    xb[5] <= 1'b0;
    $display("test remap done");
    // budget table, all six comparator slots in one case
    for (int i = 0; i < 5; i++) begin
      wr(OFF_EN, 32'(ten[i]));
      wr(OFF_LOAD, 32'(tpw[i] * 16 + tax[i]));
      for (int j = 0; j < 6; j++) wr(8'(8'h40 + 16 * j), (j < tnc[i]) ? 32'h141 : 32'h0);
      rd(OFF_STAT);
      chk(v & 32'h03FF_FFFE, {6'h0, 10'(bud(tax[i], tpw[i], tnc[i])), 11'h0,
          3'(tnc[i]), 1'(i != 0), 1'b0}, "budget");
    end
    pulse(3);
    repeat (250) @(posedge pclk);
    chk(overload, 1'b1, "overload not set");
    wr(OFF_STAT, 32'h1);
    repeat (250) @(posedge pclk);
    chk(overload, 1'b0, "overload not cleared");
    $display("test budget done");
    end_of_test;
  end
endmodule : tb_high_speed_counter_compare_budget
